// [hdl/err_pkg.sv]
// Package for the receive-side link error handler.
// Assumes a single 200 MHz system clock and a Wishbone classic register bus.
package err_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_LANES = 4;
    localparam int NUM_VC    = 4;
    localparam int VC_W      = 2;
    localparam int DT_W      = 6;
    localparam int ADR_W     = 4;

    // ****************************************************************
    // Register word addresses (byte address = index * 4)
    // ****************************************************************
    localparam logic [ADR_W-1:0] REG_STATUS  = 4'h0;
    localparam logic [ADR_W-1:0] REG_VC_STAT = 4'h1;
    localparam logic [ADR_W-1:0] REG_LEVEL   = 4'h2;
    localparam logic [ADR_W-1:0] REG_CTRL    = 4'h3;
    localparam logic [ADR_W-1:0] REG_DT_LO   = 4'h4;
    localparam logic [ADR_W-1:0] REG_DT_HI   = 4'h5;

    // ****************************************************************
    // Status bit positions (sticky, write one to clear)
    // ****************************************************************
    localparam int ST_SOT_SOFT  = 0;
    localparam int ST_SOT_SYNC  = 1;
    localparam int ST_LINE_SEQ  = 2;
    localparam int ST_DOUBLE    = 3;
    localparam int ST_CORRECTED = 4;
    localparam int ST_MISMATCH  = 5;
    localparam int ST_UNKNOWN   = 6;
    localparam int ST_W         = 7;

    // Control bits
    localparam int CTRL_INIT    = 0;
    localparam logic [31:0] DT_LO_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] DT_HI_RST = 32'hFFFF_FFFF;

    // Frame start / frame end data identifiers
    localparam logic [DT_W-1:0] DT_FRAME_START = 6'h00;
    localparam logic [DT_W-1:0] DT_FRAME_END   = 6'h01;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic            hdr_valid;
        logic [VC_W-1:0] vc;
        logic [DT_W-1:0] dt;
        logic            double_bit;
        logic            corrected;
        logic            clean;
        logic            crc_valid;
        logic            crc_bad;
    } pkt_evt_t;

    typedef struct packed {
        logic [NUM_LANES-1:0] sot_soft;
        logic [NUM_LANES-1:0] sot_sync;
        logic [NUM_LANES-1:0] line_seq;
        logic [NUM_LANES-1:0] stop;
    } lane_evt_t;

    typedef enum logic [1:0] {VC_IDLE, VC_IN_FRAME} vc_state_t;

endpackage : err_pkg

// [hdl/vc_fsm.sv]
// Per virtual channel frame tracker.
// Assumes events already synchronous to clk_i; one header event per cycle.
`timescale 1ns/1ps
module vc_fsm
    import err_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic fs_i,
    input  wire logic fe_i,
    input  wire logic crc_bad_i,
    input  wire logic unknown_i,
    input  wire logic sync_loss_i,
    output logic      frame_sync_error_o,
    output logic      frame_data_error_o,
    output logic      unknown_identifier_flag_o
);

    typedef struct packed {
        vc_state_t st;
        logic      sync_err;
        logic      data_err;
        logic      unk;
    } vc_reg_t;

    vc_reg_t state_r;
    vc_reg_t state_nxt;

    // ****************************************************************
    // Frame pairing
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r.st)
            VC_IDLE: begin
                if (fs_i) begin
                    state_nxt.st       = VC_IN_FRAME;
                    state_nxt.sync_err = 1'b0;
                end else if (fe_i) begin
                    state_nxt.sync_err = 1'b1; // RULE_19
                end
            end
            VC_IN_FRAME: begin
                if (fs_i) begin
                    state_nxt.sync_err = 1'b1; // RULE_19
                end else if (fe_i) begin
                    state_nxt.st = VC_IDLE;
                end
            end
            default: state_nxt.st = VC_IDLE;
        endcase
        if (sync_loss_i) begin
            state_nxt.sync_err = 1'b1; // RULE_05
            state_nxt.st       = VC_IDLE;
        end
        if (fe_i) begin
            state_nxt.data_err = 1'b0; // RULE_21
            state_nxt.unk      = 1'b0; // RULE_17
        end
        if (crc_bad_i) begin
            state_nxt.data_err = 1'b1; // RULE_21
        end
        if (unknown_i) begin
            state_nxt.unk = 1'b1; // RULE_17
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= '{st: VC_IDLE, sync_err: 1'b0, data_err: 1'b0, unk: 1'b0};
        end else begin
            state_r <= state_nxt; // RULE_18
        end
    end

    assign frame_sync_error_o        = state_r.sync_err;
    assign frame_data_error_o        = state_r.data_err;
    assign unknown_identifier_flag_o = state_r.unk;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_fe_clears_data;
        @(posedge clk_i) disable iff (rst_i)
        (fe_i && !crc_bad_i) |=> !frame_data_error_o;
    endproperty
    a_fe_clears_data: assert property (p_fe_clears_data) // RULE_21
        else $error("frame data error not cleared by frame end");

    property p_double_fs;
        @(posedge clk_i) disable iff (rst_i)
        (state_r.st == VC_IN_FRAME && fs_i) |=> frame_sync_error_o;
    endproperty
    a_double_fs: assert property (p_double_fs) // RULE_19
        else $error("second frame start not flagged");

endmodule : vc_fsm

// [hdl/link_err_handler.sv]
// Receive-side link error handler: lane, packet and frame level errors.
// Assumes lane and packet events arrive on the byte clock, which is sampled
// here as a plain input; lane stop states are asynchronous levels.
//
// Notes on behaviour
// [RULE_01] Soft start error is a one byte-clock pulse, caught and reported.
// [RULE_02] Sync loss error is a one byte-clock pulse, caught and reported.
// [RULE_03] Line sequence error stays high until line state changes.
// [RULE_04] Soft start error is tagged to the next packet header.
// [RULE_05] Sync loss goes to frame logic and software; discard until stop.
// [RULE_06] Line sequence error is reported to software for reconfiguration.
// [RULE_07] Lane stop states are shown to software during initialisation.
// [RULE_08] Double-bit header error flag from the ECC syndrome.
// [RULE_09] Single-bit header error corrected, corrected flag raised.
// [RULE_10] Clean flag on zero syndrome, not proof of a clean header.
// [RULE_11] Payload checksum mismatch flag after payload.
// [RULE_12] Unknown identifier flag for unrecognised data identifiers.
// [RULE_13] Double-bit error reported; reception ignored until stop state.
// [RULE_14] Corrected flag reported to software.
// [RULE_15] Clean flag qualifies the header towards frame logic.
// [RULE_16] Checksum mismatch is forwarded to frame logic.
// [RULE_17] Unknown identifier rises on decode, falls at frame end same channel.
// [RULE_18] One sequential frame tracker per virtual channel.
// [RULE_19] Frame sync error when frame start and end do not pair.
// [RULE_20] Only data lane errors are handled; clock lane assumed reliable.
// [RULE_21] Frame data error on checksum mismatch, cleared at frame end.
// [RULE_22] Reported errors registered; pulses kept sticky until cleared.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module link_err_handler
    import err_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Link side
    input  wire logic                 rx_byte_clock_i,
    input  wire lane_evt_t            lane_i,
    input  wire pkt_evt_t             pkt_i,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADR_W+1:0]     wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Frame logic outputs
    output logic                      discard_o,
    output logic                      header_valid_o,
    output logic                      payload_suspect_o,
    output logic                      soft_tag_o,
    output logic      [NUM_VC-1:0]    frame_sync_error_o,
    output logic      [NUM_VC-1:0]    frame_data_error_o,
    output logic      [NUM_VC-1:0]    unknown_identifier_flag_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0]           bclk_sh;
        lane_evt_t            lane_s1;
        lane_evt_t            lane_s2;
        pkt_evt_t             pkt_s1;
        pkt_evt_t             pkt_s2;
        logic [NUM_LANES-1:0] seq_lvl;
        logic [ST_W-1:0]      status;
        logic                 init;
        logic [31:0]          dt_lo;
        logic [31:0]          dt_hi;
        logic                 discard;
        logic                 soft_pend;
        logic                 soft_tag;
        logic                 hdr_valid;
        logic                 suspect;
        logic [31:0]          dat;
        logic                 ack;
    } top_reg_t;

    top_reg_t s_r;
    top_reg_t s_nxt;

    logic                 bclk_rise;
    logic [NUM_LANES-1:0] stop_now;
    logic                 all_stop;
    logic                 any_soft;
    logic                 any_sync;
    logic                 any_seq;
    logic                 hdr_ev;
    logic                 crc_ev;
    logic                 fs_ev;
    logic                 fe_ev;
    logic                 dt_known;
    logic                 unknown_ev;
    logic                 wb_req;
    logic [ADR_W-1:0]     wb_idx;
    logic [ST_W-1:0]      set_bits;
    logic [ST_W-1:0]      clr_bits;
    logic [NUM_VC-1:0]    fsync_w;
    logic [NUM_VC-1:0]    fdata_w;
    logic [NUM_VC-1:0]    unk_w;
    logic [NUM_VC-1:0]    fsync_r;
    logic [NUM_VC-1:0]    fdata_r;
    logic [NUM_VC-1:0]    unk_r;

    // ****************************************************************
    // Byte clock edge and event decode
    // ****************************************************************
    assign bclk_rise  = s_r.bclk_sh[1] & ~s_r.bclk_sh[2];
    assign stop_now   = s_r.lane_s2.stop;
    assign all_stop   = &stop_now;
    // Clock lane is not monitored at all
    assign any_soft   = bclk_rise & (|s_r.lane_s2.sot_soft);  // RULE_20
    assign any_sync   = bclk_rise & (|s_r.lane_s2.sot_sync);
    assign any_seq    = |s_r.lane_s2.line_seq;
    assign hdr_ev     = bclk_rise & s_r.pkt_s2.hdr_valid & ~s_r.discard;
    assign crc_ev     = bclk_rise & s_r.pkt_s2.crc_valid & ~s_r.discard;
    assign fs_ev      = hdr_ev & ~s_r.pkt_s2.double_bit & (s_r.pkt_s2.dt == DT_FRAME_START);
    assign fe_ev      = hdr_ev & ~s_r.pkt_s2.double_bit & (s_r.pkt_s2.dt == DT_FRAME_END);
    assign dt_known   = s_r.pkt_s2.dt[5] ? s_r.dt_hi[s_r.pkt_s2.dt[4:0]]
                                        : s_r.dt_lo[s_r.pkt_s2.dt[4:0]];
    assign unknown_ev = hdr_ev & ~s_r.pkt_s2.double_bit & ~dt_known;        // RULE_12
    assign wb_req     = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign wb_idx     = wb_adr_i[ADR_W+1:2];

    // ****************************************************************
    // Per virtual channel trackers
    // ****************************************************************
    genvar gv;
    generate
        for (gv = 0; gv < NUM_VC; gv++) begin : g_vc
            localparam logic [VC_W-1:0] VC_ID = VC_W'(gv);
            vc_fsm u_vc (                                                   // RULE_18
                .clk_i                     (clk_i),
                .rst_i                     (rst_i),
                .fs_i                      (fs_ev & (s_r.pkt_s2.vc == VC_ID)),
                .fe_i                      (fe_ev & (s_r.pkt_s2.vc == VC_ID)),
                .crc_bad_i                 (crc_ev & s_r.pkt_s2.crc_bad
                                            & (s_r.pkt_s2.vc == VC_ID)),
                .unknown_i                 (unknown_ev
                                            & (s_r.pkt_s2.vc == VC_ID)),
                .sync_loss_i               (any_sync),
                .frame_sync_error_o        (fsync_w[gv]),
                .frame_data_error_o        (fdata_w[gv]),
                .unknown_identifier_flag_o (unk_w[gv])
            );
        end
    endgenerate

    // ****************************************************************
    // Status set and clear
    // ****************************************************************
    always_comb begin
        set_bits = '0;
        set_bits[ST_SOT_SOFT]  = any_soft;                                  // RULE_01
        set_bits[ST_SOT_SYNC]  = any_sync;                                  // RULE_02
        set_bits[ST_LINE_SEQ]  = any_seq;                                   // RULE_06
        set_bits[ST_DOUBLE]    = hdr_ev & s_r.pkt_s2.double_bit;            // RULE_08
        set_bits[ST_CORRECTED] = hdr_ev & s_r.pkt_s2.corrected;             // RULE_09 RULE_14
        set_bits[ST_MISMATCH]  = crc_ev & s_r.pkt_s2.crc_bad;               // RULE_11
        set_bits[ST_UNKNOWN]   = unknown_ev;
        clr_bits = '0;
        if (wb_req && wb_we_i && wb_idx == REG_STATUS && wb_sel_i[0]) begin
            clr_bits = wb_dat_i[ST_W-1:0];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt         = s_r;
        s_nxt.bclk_sh = {s_r.bclk_sh[1:0], rx_byte_clock_i};
        s_nxt.lane_s1 = lane_i;
        s_nxt.lane_s2 = s_r.lane_s1;
        s_nxt.pkt_s1  = pkt_i;
        s_nxt.pkt_s2  = s_r.pkt_s1;
        s_nxt.seq_lvl = s_r.lane_s2.line_seq;                               // RULE_03
        // Set wins over clear
        s_nxt.status  = (s_r.status & ~clr_bits) | set_bits;                // RULE_22
        // Discard window ends at stop state
        if (all_stop) begin
            s_nxt.discard = 1'b0;
        end
        if (any_sync) begin
            s_nxt.discard = 1'b1;                                           // RULE_05
        end
        if (hdr_ev && s_r.pkt_s2.double_bit) begin
            s_nxt.discard = 1'b1;                                           // RULE_13
        end
        // Soft start error attaches to the next header
        s_nxt.soft_tag = 1'b0;
        if (any_soft) begin
            s_nxt.soft_pend = 1'b1;
        end
        if (hdr_ev) begin
            s_nxt.soft_tag  = s_r.soft_pend | any_soft;                     // RULE_04
            s_nxt.soft_pend = 1'b0;
        end
        s_nxt.hdr_valid = hdr_ev & s_r.pkt_s2.clean;                        // RULE_10 RULE_15
        s_nxt.suspect   = crc_ev & s_r.pkt_s2.crc_bad;                      // RULE_16
        // Register bus
        s_nxt.ack = wb_req;
        s_nxt.dat = '0;
        if (wb_req && wb_we_i) begin
            case (wb_idx)
                REG_CTRL:  if (wb_sel_i[0]) s_nxt.init = wb_dat_i[CTRL_INIT];
                REG_DT_LO: s_nxt.dt_lo = wb_dat_i;
                REG_DT_HI: s_nxt.dt_hi = wb_dat_i;
                default:   s_nxt.dat = '0;
            endcase
        end else if (wb_req) begin
            case (wb_idx)
                REG_STATUS:  s_nxt.dat = {{(32-ST_W){1'b0}}, s_r.status};
                REG_VC_STAT: s_nxt.dat = {{(32-3*NUM_VC){1'b0}}, unk_r, fdata_r, fsync_r};
                REG_LEVEL:   s_nxt.dat = {16'h0000,
                                          s_r.init ? stop_now : {NUM_LANES{1'b0}}, // RULE_07
                                          {(12-NUM_LANES){1'b0}}, s_r.seq_lvl};
                REG_CTRL:    s_nxt.dat = {31'h0000_0000, s_r.init};
                REG_DT_LO:   s_nxt.dat = s_r.dt_lo;
                REG_DT_HI:   s_nxt.dat = s_r.dt_hi;
                default:     s_nxt.dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r       <= '0;
            s_r.init  <= 1'b1;
            s_r.dt_lo <= DT_LO_RST;
            s_r.dt_hi <= DT_HI_RST;
            fsync_r   <= '0;
            fdata_r   <= '0;
            unk_r     <= '0;
        end else begin
            s_r     <= s_nxt;
            fsync_r <= fsync_w;
            fdata_r <= fdata_w;
            unk_r   <= unk_w;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign wb_dat_o                  = s_r.dat;
    assign wb_ack_o                  = s_r.ack;
    assign discard_o                 = s_r.discard;
    assign header_valid_o            = s_r.hdr_valid;
    assign payload_suspect_o         = s_r.suspect;
    assign soft_tag_o                = s_r.soft_tag;
    assign frame_sync_error_o        = fsync_r;
    assign frame_data_error_o        = fdata_r;
    assign unknown_identifier_flag_o = unk_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_soft_sticky;
        @(posedge clk_i) disable iff (rst_i)
        any_soft |=> s_r.status[ST_SOT_SOFT];
    endproperty
    a_soft_sticky: assert property (p_soft_sticky) // RULE_01
        else $error("soft start error not captured");

    property p_sync_sticky;
        @(posedge clk_i) disable iff (rst_i)
        any_sync |=> s_r.status[ST_SOT_SYNC] && discard_o;
    endproperty
    a_sync_sticky: assert property (p_sync_sticky) // RULE_02
        else $error("sync loss not captured or discard not started");

    property p_seq_level;
        @(posedge clk_i) disable iff (rst_i)
        any_seq |=> s_r.status[ST_LINE_SEQ];
    endproperty
    a_seq_level: assert property (p_seq_level) // RULE_03
        else $error("line sequence error not reported");

    property p_discard_hold;
        @(posedge clk_i) disable iff (rst_i)
        (discard_o && !all_stop) |=> discard_o;
    endproperty
    a_discard_hold: assert property (p_discard_hold) // RULE_05
        else $error("discard ended before stop state");

    property p_double;
        @(posedge clk_i) disable iff (rst_i)
        (hdr_ev && s_r.pkt_s2.double_bit) |=> discard_o && s_r.status[ST_DOUBLE];
    endproperty
    a_double: assert property (p_double) // RULE_13
        else $error("double-bit header error not handled");

    property p_clean;
        @(posedge clk_i) disable iff (rst_i)
        header_valid_o |-> $past(hdr_ev) && $past(s_r.pkt_s2.clean);
    endproperty
    a_clean: assert property (p_clean) // RULE_15
        else $error("header valid without clean syndrome");

    property p_mismatch;
        @(posedge clk_i) disable iff (rst_i)
        (crc_ev && s_r.pkt_s2.crc_bad) |=> payload_suspect_o ##1 !payload_suspect_o;
    endproperty
    a_mismatch: assert property (p_mismatch) // RULE_16
        else $error("payload mismatch not forwarded as pulse");

    property p_wb_ack;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) // RULE_22
        else $error("ack longer than one cycle");

    property p_soft_tag;
        @(posedge clk_i) disable iff (rst_i)
        (hdr_ev && s_r.soft_pend) |=> soft_tag_o;
    endproperty
    a_soft_tag: assert property (p_soft_tag) // RULE_04
        else $error("soft start error not tagged to header");

    property p_corrected;
        @(posedge clk_i) disable iff (rst_i)
        (hdr_ev && s_r.pkt_s2.corrected) |=> s_r.status[ST_CORRECTED];
    endproperty
    a_corrected: assert property (p_corrected) // RULE_09
        else $error("corrected header not reported");

    property p_hdr_clean;
        @(posedge clk_i) disable iff (rst_i)
        (hdr_ev && s_r.pkt_s2.clean) |=> header_valid_o;
    endproperty
    a_hdr_clean: assert property (p_hdr_clean) // RULE_10
        else $error("clean header not qualified");

    property p_unknown;
        @(posedge clk_i) disable iff (rst_i)
        unknown_ev |=> s_r.status[ST_UNKNOWN];
    endproperty
    a_unknown: assert property (p_unknown) // RULE_12
        else $error("unknown identifier not reported");

    c_soft: cover property (@(posedge clk_i) disable iff (rst_i) soft_tag_o);
    c_sync: cover property (@(posedge clk_i) disable iff (rst_i) discard_o ##1 !discard_o);
    c_fs:   cover property (@(posedge clk_i) disable iff (rst_i) fs_ev ##[1:200] fe_ev);
    c_unk:  cover property (@(posedge clk_i) disable iff (rst_i) |unknown_identifier_flag_o);

endmodule : link_err_handler

// [tb/link_far_end.sv]
// Far-end model: lane modules and header decoder on a free byte clock.
// Assumes the bench calls its tasks; events change on the falling byte clock.
`timescale 1ns/1ps
module link_far_end
    import err_pkg::*;
(
    output logic      bclk_o,
    output lane_evt_t lane_o,
    output pkt_evt_t  pkt_o
);
    initial begin
        bclk_o = 1'b0;
        lane_o = 16'h000F;
        pkt_o  = '0;
    end
    always #32 bclk_o = ~bclk_o;
    task automatic lset(input lane_evt_t v);
        @(negedge bclk_o);
        lane_o <= v;
    endtask : lset
    task automatic hdr(input logic [1:0] vc, input logic [5:0] dt, input logic [2:0] ecc);
        @(negedge bclk_o);
        pkt_o <= {1'b1, vc, dt, ecc, 2'b00};
        @(negedge bclk_o);
        pkt_o <= '0;
    endtask : hdr
    task automatic crc(input logic bad);
        @(negedge bclk_o);
        pkt_o <= {12'h000, 1'b1, bad};
        @(negedge bclk_o);
        pkt_o <= '0;
    endtask : crc
endmodule : link_far_end

// [tb/link_err_handler_bench.sv]
// Bench for the link error handler: register tasks and event scenarios.
// Assumes the far-end model drives the link side and Wishbone reaches the registers.
`timescale 1ns/1ps
module link_err_handler_bench
    import err_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [5:0] wb_adr = '0;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat = '0, wb_dat_o, q;
    logic wb_ack_o, discard_o, header_valid_o, payload_suspect_o, soft_tag_o, bclk;
    logic [3:0] fse, fde, unk;
    lane_evt_t lane;
    pkt_evt_t  pkt;
    int miscompares = 0, checked = 0, cycles = 0, tags = 0, sus = 0, hv = 0;
    logic tag_d = 1'b0, sus_d = 1'b0;
    always #2.5 clk_i = ~clk_i;
    link_far_end u_far (.bclk_o(bclk), .lane_o(lane), .pkt_o(pkt));
    link_err_handler u_dut (.clk_i(clk_i), .rst_i(rst_i), .rx_byte_clock_i(bclk),
        .lane_i(lane), .pkt_i(pkt), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .discard_o(discard_o), .header_valid_o(header_valid_o),
        .payload_suspect_o(payload_suspect_o), .soft_tag_o(soft_tag_o),
        .frame_sync_error_o(fse), .frame_data_error_o(fde), .unknown_identifier_flag_o(unk));
    // ****************************************************************
    // Pulse counters and watchdog
    // ****************************************************************
    always @(posedge clk_i) begin
        tag_d <= soft_tag_o;
        sus_d <= payload_suspect_o;
        if (soft_tag_o === 1'b1 && tag_d !== 1'b1) tags++;
        if (payload_suspect_o === 1'b1 && sus_d !== 1'b1) sus++;
        if (header_valid_o === 1'b1) hv++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= {a, 2'b00};
        wb_dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : bus
    task automatic rc(input logic [ADR_W-1:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rc
    task automatic settle();
        repeat (20) @(posedge clk_i);
    endtask : settle
    task automatic end_sim();
        $display("miscompares %0d checked %0d", miscompares, checked);
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(REG_STATUS, 32'h0);
        rc(REG_CTRL, 32'h1);
        rc(REG_DT_LO, DT_LO_RST);
        rc(REG_DT_HI, DT_HI_RST);
        bus(1'b1, 4'h7, 32'hFFFF_FFFF);
        rc(4'h7, 32'h0);
        settle();
        rc(REG_LEVEL, 32'h0000_F000);
        u_far.lset(16'hF00F);
        u_far.lset(16'h000F);
        u_far.hdr(2'h0, DT_FRAME_START, 3'b001);
        u_far.crc(1'b1);
        settle();
        chk({28'h0, fde}, 32'h1);
        u_far.hdr(2'h0, DT_FRAME_END, 3'b001);
        settle();
        chk({28'h0, fde}, 32'h0);
        chk(tags, 32'h1);
        chk(sus, 32'h1);
        chk(hv != 0, 32'h1);
        rc(REG_STATUS, 32'h21);
        bus(1'b1, REG_STATUS, 32'h7F);
        rc(REG_STATUS, 32'h0);
        u_far.hdr(2'h1, DT_FRAME_START, 3'b010);
        u_far.crc(1'b0);
        u_far.hdr(2'h1, DT_FRAME_END, 3'b001);
        bus(1'b1, REG_DT_HI, 32'hBFFF_FFFF);
        u_far.hdr(2'h2, DT_FRAME_START, 3'b001);
        u_far.hdr(2'h2, 6'h3E, 3'b001);
        settle();
        rc(REG_STATUS, 32'h50);
        rc(REG_VC_STAT, 32'h400);
        u_far.hdr(2'h2, DT_FRAME_END, 3'b001);
        u_far.hdr(2'h3, DT_FRAME_START, 3'b001);
        u_far.hdr(2'h3, DT_FRAME_START, 3'b001);
        settle();
        chk({28'h0, unk}, 32'h0);
        chk({28'h0, fse}, 32'h8);
        bus(1'b1, REG_STATUS, 32'h7F);
        u_far.lset(16'h00F0);
        settle();
        rc(REG_LEVEL, 32'hF);
        u_far.lset(16'h0000);
        u_far.hdr(2'h0, DT_FRAME_START, 3'b100);
        u_far.crc(1'b1);
        settle();
        chk(discard_o, 32'h1);
        rc(REG_STATUS, 32'h0C);
        u_far.lset(16'h000F);
        settle();
        chk(discard_o, 32'h0);
        u_far.lset(16'h0000);
        u_far.lset(16'h0F00);
        u_far.lset(16'h0000);
        settle();
        chk(discard_o, 32'h1);
        chk({28'h0, fse}, 32'hF);
        rc(REG_STATUS, 32'h0E);
        wb_sel <= 4'hE;
        bus(1'b1, REG_STATUS, 32'h7F);
        wb_sel <= 4'hF;
        rc(REG_STATUS, 32'h0E);
        u_far.lset(16'h000F);
        bus(1'b1, REG_CTRL, 32'h0);
        settle();
        chk(discard_o, 32'h0);
        rc(REG_LEVEL, 32'h0);
        end_sim();
    end
endmodule : link_err_handler_bench
